// file: logic/pbm_cfg.svh
// offsets, field positions and reset values of the bus-master transfer block
// assumes byte offsets within one 64-byte operation-register window
`ifndef PBM_CFG_SVH
`define PBM_CFG_SVH

// ------------------------------------------------------------
// register offsets (byte addresses)
// ------------------------------------------------------------
`define PBM_OFF_OUT_MBX0 6'h00
`define PBM_OFF_IN_MBX0 6'h10
`define PBM_OFF_WR_ADDR 6'h24
`define PBM_OFF_WR_CNT 6'h28
`define PBM_OFF_RD_ADDR 6'h2C
`define PBM_OFF_RD_CNT 6'h30
`define PBM_OFF_MBX_FLAGS 6'h34
`define PBM_OFF_IRQ_CSR 6'h38
`define PBM_OFF_BM_CTRL 6'h3C

// ------------------------------------------------------------
// irq_control_status fields
// ------------------------------------------------------------
`define PBM_ICSR_RW_MASK 32'h0000DF1F
`define PBM_ICSR_FLAG_MASK 32'h003F0000
`define PBM_ICSR_SUMMARY 23
`define PBM_ICSR_TABORT 21
`define PBM_ICSR_MABORT 20
`define PBM_ICSR_RD_DONE 19
`define PBM_ICSR_WR_DONE 18
`define PBM_ICSR_IN_MBX 17
`define PBM_ICSR_OUT_MBX 16
`define PBM_ICSR_RD_IEN 15
`define PBM_ICSR_WR_IEN 14
`define PBM_ICSR_IN_IEN 12
`define PBM_ICSR_OUT_IEN 4

// ------------------------------------------------------------
// bus-master control fields and reset values
// ------------------------------------------------------------
`define PBM_CTRL_WR_EN 0
`define PBM_CTRL_RD_EN 1
`define PBM_RST_WORD 32'h00000000
`define PBM_RST_ADDR 30'h00000000
`define PBM_FULL_WORD_BYTES 32'h00000004

`endif

// file: logic/pbm_pkg.sv
// types shared by the bus-master transfer block and its bench
// assumes a 32-bit data path
package pbm_pkg;

	// ------------------------------------------------------------
	// master engine states
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		PBM_IDLE,
		PBM_WR_PHASE,
		PBM_RD_PHASE
	} pbm_state_t;

	// ------------------------------------------------------------
	// one data-phase request toward the bus
	// ------------------------------------------------------------
	typedef struct packed {
		logic valid;
		logic write;
		logic [31:0] addr;
		logic [3:0] be;
		logic [31:0] wdata;
	} pbm_mreq_t;

	// ------------------------------------------------------------
	// completion of a data phase from the bus
	// ------------------------------------------------------------
	typedef struct packed {
		logic ack;
		logic tabort;
		logic mabort;
		logic [31:0] rdata;
	} pbm_mrsp_t;

endpackage

// file: logic/pbm_fifo.sv
// small synchronous fifo in the pci-to-add-on read data path
// assumes one clock; storage is flip-flops
`timescale 1ns/10ps
module pbm_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// filling side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// draining side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wr_ptr;
		logic [AW-1:0] rd_ptr;
		logic [AW:0] count;
	} pbm_fifo_st_t;

	pbm_fifo_st_t st_reg;
	pbm_fifo_st_t st_next;
	logic push;
	logic pop;

	assign in_ready = (st_reg.count != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
	assign out_valid = (st_reg.count != '0);
	assign out_data = st_reg.mem[st_reg.rd_ptr];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	// ------------------------------------------------------------
	// pointer and count update
	// ------------------------------------------------------------
	always_comb begin
		st_next = st_reg;
		if (push) begin
			st_next.mem[st_reg.wr_ptr] = in_data;
			st_next.wr_ptr = (st_reg.wr_ptr == AW'(DEPTH - 1)) ? '0 : st_reg.wr_ptr + 1'b1;
		end
		if (pop) begin
			st_next.rd_ptr = (st_reg.rd_ptr == AW'(DEPTH - 1)) ? '0 : st_reg.rd_ptr + 1'b1;
		end
		if (push && !pop) begin
			st_next.count = st_reg.count + 1'b1;
		end else if (pop && !push) begin
			st_next.count = st_reg.count - 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end
endmodule

// file: logic/pbm_top.sv
// bus-master transfer control, mailbox status and interrupt sources
// assumes the pci target, pci master and add-on ports all run on clk_sys
//
// What this block does
// [RQ1] write count holds bytes left add-on to pci, falls per master write
// [RQ2] read count holds bytes left pci to add-on, falls per master read
// [RQ3] count at zero stops that transfer; enabled interrupt may follow
// [RQ4] odd byte count ends with a partial word using remaining lanes only
// [RQ5] read address is a 30-bit word counter, low two bits zero
// [RQ6] software gives non-zero length and word-aligned start address
// [RQ7] read address always points at next unread location
// [RQ8] address counter readable by target access during a transfer
// [RQ9] master read address phase drives the two low bits as zero
// [RQ10] address bit one always zero as master, signalling burst capable
// [RQ11] address and count registers also reachable from the add-on side
// [RQ12] mailbox status: outgoing bytes in 15:0, incoming in 31:16, one full
// [RQ13] status bit sets on source write, clears on destination read
// [RQ14] incoming bit is 16 plus four times mailbox index plus byte
// [RQ15] outgoing bit is four times mailbox index plus byte
// [RQ16] incoming mailboxes carry add-on to pci, outgoing pci to add-on
// [RQ17] interrupt sources: counts zero, mailbox events, target and master abort
// [RQ18] control register enables sources, shows cause, acknowledges it
// [RQ19] status flags clear on write one; control fields plain read/write
// [RQ20] separate enables gate read-done and write-done interrupts
// [RQ21] read-only summary bit is the or of condition bits 19..16
// [RQ22] each data phase lowers the count by bytes moved
`timescale 1ns/10ps
`include "pbm_cfg.svh"
module pbm_top #(
	parameter int FIFO_DEPTH = 8
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// pci target register access
	input wire logic tgt_wr,
	input wire logic tgt_rd,
	input wire logic [5:0] tgt_addr,
	input wire logic [3:0] tgt_be,
	input wire logic [31:0] tgt_wdata,
	output logic [31:0] tgt_rdata,
	// pci master data phases
	output pbm_pkg::pbm_mreq_t mst_req,
	input wire pbm_pkg::pbm_mrsp_t mst_rsp,
	// add-on register access
	input wire logic ao_bm_mode,
	input wire logic ao_wr,
	input wire logic ao_rd,
	input wire logic [5:0] ao_addr,
	input wire logic [3:0] ao_be,
	input wire logic [31:0] ao_wdata,
	output logic [31:0] ao_rdata,
	// add-on write stream toward pci
	input wire logic ao_wdat_valid,
	input wire logic [31:0] ao_wdat,
	output logic ao_wdat_ready,
	// add-on read stream from pci
	output logic ao_rdat_valid,
	input wire logic ao_rdat_ready,
	output logic [31:0] ao_rdat,
	// status
	output logic pci_irq,
	output logic wr_cnt_zero,
	output logic rd_cnt_zero
);
	typedef struct packed {
		pbm_pkg::pbm_state_t fsm;
		logic [29:0] wr_addr;
		logic [31:0] wr_cnt;
		logic [29:0] rd_addr;
		logic [31:0] rd_cnt;
		logic [1:0] ctrl;
		logic [31:0] icsr;
		logic [31:0] mailbox_full_flags;
		logic [7:0][31:0] mbox;
		logic [31:0] tgt_rdata;
		logic [31:0] ao_rdata;
		pbm_pkg::pbm_mreq_t req;
	} pbm_st_t;

	pbm_st_t st_reg;
	pbm_st_t st_next;
	logic fifo_in_ready;
	logic fifo_push;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] lane_mask(input logic [3:0] be);
		lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
			input logic [3:0] be);
		merge = (old & ~lane_mask(be)) | (wd & lane_mask(be));
	endfunction

	// byte lanes left for the next data phase
	function automatic logic [3:0] lanes_left(input logic [31:0] cnt);
		if (cnt >= `PBM_FULL_WORD_BYTES) begin
			lanes_left = 4'hF;
		end else begin
			case (cnt[1:0])
				2'h3: lanes_left = 4'h7;
				2'h2: lanes_left = 4'h3;
				default: lanes_left = 4'h1;
			endcase
		end
	endfunction

	function automatic logic [31:0] bytes_moved(input logic [31:0] cnt);
		bytes_moved = (cnt >= `PBM_FULL_WORD_BYTES) ? `PBM_FULL_WORD_BYTES : cnt;
	endfunction

	function automatic logic [31:0] reg_view(input pbm_st_t s, input logic [5:0] a);
		logic [31:0] v;
		v = `PBM_RST_WORD;
		if (a[5:4] != 2'h3 && a < `PBM_OFF_WR_ADDR && a[5] == 1'b0) begin
			v = s.mbox[a[4:2]];
		end else begin
			case (a)
				`PBM_OFF_WR_ADDR: v = {s.wr_addr, 2'h0};
				`PBM_OFF_WR_CNT: v = s.wr_cnt;
				`PBM_OFF_RD_ADDR: v = {s.rd_addr, 2'h0}; // [RQ5] [RQ8]
				`PBM_OFF_RD_CNT: v = s.rd_cnt;
				`PBM_OFF_MBX_FLAGS: v = s.mailbox_full_flags; // [RQ12]
				`PBM_OFF_IRQ_CSR: begin
					v = s.icsr;
					v[`PBM_ICSR_SUMMARY] = |s.icsr[19:16]; // [RQ21]
				end
				`PBM_OFF_BM_CTRL: v = {30'h00000000, s.ctrl};
				default: v = `PBM_RST_WORD;
			endcase
		end
		reg_view = v;
	endfunction

	// ------------------------------------------------------------
	// read data buffer toward the add-on
	// ------------------------------------------------------------
	assign fifo_push = (st_reg.fsm == pbm_pkg::PBM_RD_PHASE) & mst_rsp.ack;

	pbm_fifo #(
		.WIDTH(32),
		.DEPTH(FIFO_DEPTH)
	) u_rd_fifo (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.in_valid(fifo_push),
		.in_ready(fifo_in_ready),
		.in_data(mst_rsp.rdata),
		.out_valid(ao_rdat_valid),
		.out_ready(ao_rdat_ready),
		.out_data(ao_rdat)
	);

	assign mst_req = st_reg.req;
	assign tgt_rdata = st_reg.tgt_rdata;
	assign ao_rdata = st_reg.ao_rdata;
	assign wr_cnt_zero = (st_reg.wr_cnt == `PBM_RST_WORD);
	assign rd_cnt_zero = (st_reg.rd_cnt == `PBM_RST_WORD);
	assign pci_irq = |st_reg.icsr[21:16]; // [RQ17] [RQ18]
	assign ao_wdat_ready = (st_reg.fsm == pbm_pkg::PBM_WR_PHASE) & mst_rsp.ack;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		logic [31:0] flag_set;
		logic [31:0] flag_clr;
		logic [31:0] mb_set;
		logic [31:0] mb_clr;
		logic [31:0] bm;
		logic [4:0] out_sel;
		logic [4:0] in_sel;
		logic [31:0] left;
		flag_set = '0;
		flag_clr = '0;
		mb_set = '0;
		mb_clr = '0;
		bm = '0;
		left = '0;
		out_sel = {1'b0, st_reg.icsr[3:0]};
		in_sel = 5'h10 + {1'b0, st_reg.icsr[11:8]};
		st_next = st_reg;

		// ------------------------------------------------------------
		// pci target access
		// ------------------------------------------------------------
		if (tgt_rd) begin
			st_next.tgt_rdata = reg_view(st_reg, tgt_addr);
			if (tgt_addr[5:4] == 2'h1) begin
				for (int b = 0; b < 4; b++) begin
					if (tgt_be[b]) begin
						mb_clr[16 + 4 * tgt_addr[3:2] + b] = 1'b1; // [RQ13] [RQ14]
					end
				end
			end
		end
		if (tgt_wr) begin
			bm = lane_mask(tgt_be);
			case (tgt_addr)
				`PBM_OFF_WR_ADDR: st_next.wr_addr = 30'(merge({st_reg.wr_addr, 2'h0},
					tgt_wdata, tgt_be) >> 2);
				`PBM_OFF_WR_CNT: st_next.wr_cnt = merge(st_reg.wr_cnt, tgt_wdata, tgt_be);
				`PBM_OFF_RD_ADDR: st_next.rd_addr = 30'(merge({st_reg.rd_addr, 2'h0},
					tgt_wdata, tgt_be) >> 2); // [RQ5]
				`PBM_OFF_RD_CNT: st_next.rd_cnt = merge(st_reg.rd_cnt, tgt_wdata, tgt_be);
				`PBM_OFF_IRQ_CSR: begin
					st_next.icsr = (st_reg.icsr & ~(`PBM_ICSR_RW_MASK & bm))
						| (tgt_wdata & `PBM_ICSR_RW_MASK & bm); // [RQ19]
					flag_clr = tgt_wdata & `PBM_ICSR_FLAG_MASK & bm; // [RQ19]
				end
				`PBM_OFF_BM_CTRL: if (tgt_be[0]) begin
					st_next.ctrl = tgt_wdata[1:0];
				end
				default: begin
					if (tgt_addr[5:4] == 2'h0) begin
						st_next.mbox[tgt_addr[3:2]] = merge(st_reg.mbox[tgt_addr[3:2]],
							tgt_wdata, tgt_be); // [RQ16]
						for (int b = 0; b < 4; b++) begin
							if (tgt_be[b]) begin
								mb_set[4 * tgt_addr[3:2] + b] = 1'b1; // [RQ13] [RQ15]
							end
						end
					end
				end
			endcase
		end

		// ------------------------------------------------------------
		// add-on access
		// ------------------------------------------------------------
		if (ao_rd) begin
			st_next.ao_rdata = reg_view(st_reg, ao_addr);
			if (ao_addr[5:4] == 2'h0) begin
				for (int b = 0; b < 4; b++) begin
					if (ao_be[b]) begin
						mb_clr[4 * ao_addr[3:2] + b] = 1'b1; // [RQ13] [RQ15]
					end
				end
			end
		end
		if (ao_wr) begin
			case (ao_addr)
				`PBM_OFF_WR_ADDR: if (ao_bm_mode) begin
					st_next.wr_addr = 30'(merge({st_reg.wr_addr, 2'h0}, ao_wdata, ao_be) >> 2);
				end // [RQ11]
				`PBM_OFF_WR_CNT: if (ao_bm_mode) begin
					st_next.wr_cnt = merge(st_reg.wr_cnt, ao_wdata, ao_be);
				end // [RQ11]
				`PBM_OFF_RD_ADDR: if (ao_bm_mode) begin
					st_next.rd_addr = 30'(merge({st_reg.rd_addr, 2'h0}, ao_wdata, ao_be) >> 2);
				end // [RQ11]
				`PBM_OFF_RD_CNT: if (ao_bm_mode) begin
					st_next.rd_cnt = merge(st_reg.rd_cnt, ao_wdata, ao_be);
				end // [RQ11]
				default: begin
					if (ao_addr[5:4] == 2'h1) begin
						st_next.mbox[{1'b1, ao_addr[3:2]}] =
							merge(st_reg.mbox[{1'b1, ao_addr[3:2]}], ao_wdata, ao_be); // [RQ16]
						for (int b = 0; b < 4; b++) begin
							if (ao_be[b]) begin
								mb_set[16 + 4 * ao_addr[3:2] + b] = 1'b1; // [RQ13] [RQ14]
							end
						end
					end
				end
			endcase
		end

		// mailbox interrupt events on the selected byte
		if (st_reg.icsr[`PBM_ICSR_OUT_IEN] && mb_clr[out_sel]) begin
			flag_set[`PBM_ICSR_OUT_MBX] = 1'b1; // [RQ17]
		end
		if (st_reg.icsr[`PBM_ICSR_IN_IEN] && mb_set[in_sel]) begin
			flag_set[`PBM_ICSR_IN_MBX] = 1'b1; // [RQ17]
		end

		// ------------------------------------------------------------
		// master engine
		// ------------------------------------------------------------
		case (st_reg.fsm)
			pbm_pkg::PBM_IDLE: begin
				st_next.req.valid = 1'b0;
				if (st_reg.ctrl[`PBM_CTRL_WR_EN] && st_reg.wr_cnt != `PBM_RST_WORD
						&& ao_wdat_valid) begin
					st_next.fsm = pbm_pkg::PBM_WR_PHASE;
					st_next.req.valid = 1'b1;
					st_next.req.write = 1'b1;
					st_next.req.addr = {st_reg.wr_addr, 2'h0}; // [RQ10]
					st_next.req.be = lanes_left(st_reg.wr_cnt); // [RQ4]
					st_next.req.wdata = ao_wdat;
				end else if (st_reg.ctrl[`PBM_CTRL_RD_EN] && st_reg.rd_cnt != `PBM_RST_WORD
						&& fifo_in_ready) begin
					st_next.fsm = pbm_pkg::PBM_RD_PHASE;
					st_next.req.valid = 1'b1;
					st_next.req.write = 1'b0;
					st_next.req.addr = {st_reg.rd_addr, 2'h0}; // [RQ9] [RQ10]
					st_next.req.be = lanes_left(st_reg.rd_cnt); // [RQ4]
					st_next.req.wdata = `PBM_RST_WORD;
				end
			end
			pbm_pkg::PBM_WR_PHASE: begin
				if (mst_rsp.tabort || mst_rsp.mabort) begin
					st_next.fsm = pbm_pkg::PBM_IDLE;
					st_next.req.valid = 1'b0;
					st_next.ctrl[`PBM_CTRL_WR_EN] = 1'b0;
				end else if (mst_rsp.ack) begin
					st_next.fsm = pbm_pkg::PBM_IDLE;
					st_next.req.valid = 1'b0;
					left = st_reg.wr_cnt - bytes_moved(st_reg.wr_cnt); // [RQ1] [RQ22]
					st_next.wr_cnt = left;
					st_next.wr_addr = st_reg.wr_addr + 30'h1;
					if (left == `PBM_RST_WORD) begin
						st_next.ctrl[`PBM_CTRL_WR_EN] = 1'b0; // [RQ3]
						flag_set[`PBM_ICSR_WR_DONE] = st_reg.icsr[`PBM_ICSR_WR_IEN]; // [RQ20]
					end
				end
			end
			pbm_pkg::PBM_RD_PHASE: begin
				if (mst_rsp.tabort || mst_rsp.mabort) begin
					st_next.fsm = pbm_pkg::PBM_IDLE;
					st_next.req.valid = 1'b0;
					st_next.ctrl[`PBM_CTRL_RD_EN] = 1'b0;
				end else if (mst_rsp.ack) begin
					st_next.fsm = pbm_pkg::PBM_IDLE;
					st_next.req.valid = 1'b0;
					left = st_reg.rd_cnt - bytes_moved(st_reg.rd_cnt); // [RQ2] [RQ22]
					st_next.rd_cnt = left;
					st_next.rd_addr = st_reg.rd_addr + 30'h1; // [RQ7]
					if (left == `PBM_RST_WORD) begin
						st_next.ctrl[`PBM_CTRL_RD_EN] = 1'b0; // [RQ3]
						flag_set[`PBM_ICSR_RD_DONE] = st_reg.icsr[`PBM_ICSR_RD_IEN]; // [RQ20]
					end
				end
			end
			default: begin
				st_next.fsm = pbm_pkg::PBM_IDLE;
				st_next.req.valid = 1'b0;
			end
		endcase
		if (st_reg.fsm != pbm_pkg::PBM_IDLE) begin
			flag_set[`PBM_ICSR_TABORT] = mst_rsp.tabort; // [RQ17]
			flag_set[`PBM_ICSR_MABORT] = mst_rsp.mabort; // [RQ17]
		end

		// set wins over clear for both flag groups
		st_next.icsr = (st_next.icsr & ~flag_clr) | (flag_set & `PBM_ICSR_FLAG_MASK); // [RQ19]
		st_next.mailbox_full_flags = (st_reg.mailbox_full_flags & ~mb_clr) | mb_set; // [RQ13]
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end
endmodule

// file: tb/pbm_mem_model.sv
// far-side memory that answers the master's data phases after a set wait
// assumes one phase outstanding; the bench fills mem at time zero
`timescale 1ns/10ps
module pbm_mem_model (
	// clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// wait per phase; fault 1 target abort, 2 master abort
	input wire logic [3:0] lat,
	input wire logic [1:0] fault,
	// master link
	input wire pbm_pkg::pbm_mreq_t mst_req,
	output pbm_pkg::pbm_mrsp_t mst_rsp
);
	logic [31:0] mem [64];
	logic [3:0] cnt;
	wire logic [5:0] idx = mst_req.addr[7:2];
	wire logic ok = (fault == 2'h0);

	// read data is only meaningful with ack, so it toggles otherwise
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			cnt <= 4'h0;
			mst_rsp <= '0;
		end else begin
			mst_rsp.ack <= 1'b0;
			mst_rsp.tabort <= 1'b0;
			mst_rsp.mabort <= 1'b0;
			mst_rsp.rdata <= ~mst_rsp.rdata;
			if (!mst_req.valid || mst_rsp.ack || mst_rsp.tabort || mst_rsp.mabort) begin
				cnt <= 4'h0;
			end else if (cnt != lat) begin
				cnt <= cnt + 4'h1;
			end else begin
				mst_rsp.tabort <= (fault == 2'h1);
				mst_rsp.mabort <= (fault == 2'h2);
				mst_rsp.ack <= ok;
				if (ok && !mst_req.write) mst_rsp.rdata <= mem[idx];
				for (int b = 0; b < 4; b++) begin
					if (ok && mst_req.write && mst_req.be[b]) mem[idx][8*b +: 8] <= mst_req.wdata[8*b +: 8];
				end
			end
		end
	end
endmodule

// file: tb/pbm_top_chk.sv
// port checker for the bus-master block
// assumes one clock domain, clk_sys with arst_n
`timescale 1ns/10ps
module pbm_top_chk (
	// clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// watched ports
	input wire logic tgt_rd,
	input wire logic [31:0] tgt_rdata,
	input wire pbm_pkg::pbm_mreq_t mst_req,
	input wire pbm_pkg::pbm_mrsp_t mst_rsp,
	input wire logic ao_wdat_ready,
	input wire logic ao_rdat_valid,
	input wire logic ao_rdat_ready,
	input wire logic [31:0] ao_rdat,
	input wire logic rd_cnt_zero
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!arst_n);

	sequence s_end;
		mst_req.valid && (mst_rsp.ack || mst_rsp.tabort || mst_rsp.mabort);
	endsequence
	sequence s_rd_part;
		mst_req.valid && !mst_req.write && mst_rsp.ack && mst_req.be != 4'hF;
	endsequence

	property p_addr_low;
		mst_req.valid |-> mst_req.addr[1:0] == 2'h0;
	endproperty
	property p_hold;
		mst_req.valid && !(mst_rsp.ack || mst_rsp.tabort || mst_rsp.mabort)
			|=> mst_req.valid && $stable(mst_req);
	endproperty
	property p_end;
		s_end |=> !mst_req.valid;
	endproperty
	property p_be;
		mst_req.valid |-> mst_req.be inside {4'hF, 4'h7, 4'h3, 4'h1};
	endproperty
	property p_wr_ready;
		ao_wdat_ready == (mst_req.valid && mst_req.write && mst_rsp.ack);
	endproperty
	property p_part_last;
		s_rd_part |-> ##[1:2] rd_cnt_zero;
	endproperty
	property p_stop_rd;
		rd_cnt_zero [*3] |-> !(mst_req.valid && !mst_req.write);
	endproperty
	property p_rdata_hold;
		!tgt_rd |=> $stable(tgt_rdata);
	endproperty
	property p_fifo_hold;
		ao_rdat_valid && !ao_rdat_ready |=> ao_rdat_valid && $stable(ao_rdat);
	endproperty

	a_addr_low: assert property (p_addr_low)
		else $error("master address low bits not zero");
	a_hold: assert property (p_hold)
		else $error("master request changed before its answer");
	a_end: assert property (p_end)
		else $error("master request stayed up after its answer");
	a_be: assert property (p_be)
		else $error("byte enables not a leading lane group");
	a_wr_ready: assert property (p_wr_ready)
		else $error("write stream not consumed with its data phase");
	a_part_last: assert property (p_part_last)
		else $error("partial read word was not the last");
	a_stop_rd: assert property (p_stop_rd)
		else $error("read phase issued with zero count");
	a_rdata_hold: assert property (p_rdata_hold)
		else $error("target read data moved without a read");
	a_fifo_hold: assert property (p_fifo_hold)
		else $error("read stream word dropped while stalled");
endmodule

bind pbm_top pbm_top_chk pbm_top_chk_inst (.clk_sys(clk_sys), .arst_n(arst_n), .tgt_rd(tgt_rd),
	.tgt_rdata(tgt_rdata), .mst_req(mst_req), .mst_rsp(mst_rsp), .ao_wdat_ready(ao_wdat_ready),
	.ao_rdat_valid(ao_rdat_valid), .ao_rdat_ready(ao_rdat_ready), .ao_rdat(ao_rdat),
	.rd_cnt_zero(rd_cnt_zero));

// file: tb/tb.sv
// bench for the bus-master block: registers, mailboxes, transfers, aborts
// assumes the memory model on the master link and a stallable read stream
`timescale 1ns/10ps
module tb;
	logic clk_sys, arst_n, tgt_wr, tgt_rd, ao_bm_mode, ao_wr, ao_rd;
	logic ao_wdat_valid, ao_rdat_ready, ao_wdat_ready, ao_rdat_valid;
	logic pci_irq, wr_cnt_zero, rd_cnt_zero;
	logic [5:0] tgt_addr, ao_addr;
	logic [3:0] tgt_be, ao_be, lat;
	logic [1:0] fault;
	logic [31:0] tgt_wdata, tgt_rdata, ao_wdata, ao_rdata, ao_rdat;
	logic [31:0] ao_wdat = 32'hA0B0C0D0;
	pbm_pkg::pbm_mreq_t mst_req;
	pbm_pkg::pbm_mrsp_t mst_rsp;
	int n_mismatch = 0;
	int samples_checked = 0;
	int cyc = 0;
	logic [31:0] log_a[$], log_d[$];
	logic [3:0] log_be[$];
	logic [5:0] offs [5] = '{6'h2C, 6'h30, 6'h34, 6'h38, 6'h20};

	pbm_top pbm_top_inst (.clk_sys(clk_sys), .arst_n(arst_n), .tgt_wr(tgt_wr), .tgt_rd(tgt_rd),
		.tgt_addr(tgt_addr), .tgt_be(tgt_be), .tgt_wdata(tgt_wdata), .tgt_rdata(tgt_rdata),
		.mst_req(mst_req), .mst_rsp(mst_rsp), .ao_bm_mode(ao_bm_mode), .ao_wr(ao_wr),
		.ao_rd(ao_rd), .ao_addr(ao_addr), .ao_be(ao_be), .ao_wdata(ao_wdata), .ao_rdata(ao_rdata),
		.ao_wdat_valid(ao_wdat_valid), .ao_wdat(ao_wdat), .ao_wdat_ready(ao_wdat_ready),
		.ao_rdat_valid(ao_rdat_valid), .ao_rdat_ready(ao_rdat_ready), .ao_rdat(ao_rdat),
		.pci_irq(pci_irq), .wr_cnt_zero(wr_cnt_zero), .rd_cnt_zero(rd_cnt_zero));
	pbm_mem_model pbm_mem_model_inst (.clk_sys(clk_sys), .arst_n(arst_n), .lat(lat),
		.fault(fault), .mst_req(mst_req), .mst_rsp(mst_rsp));

	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	// ------------------------------------------------------------
	// logs, write stream source and hang limit
	// ------------------------------------------------------------
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (mst_req.valid && mst_rsp.ack) begin
			log_a.push_back(mst_req.addr);
			log_be.push_back(mst_req.be);
		end
		if (ao_rdat_valid && ao_rdat_ready) log_d.push_back(ao_rdat);
		if (ao_wdat_valid && ao_wdat_ready) ao_wdat <= ao_wdat + 32'h01010101;
		if (cyc == 5000) begin
			n_mismatch++;
			close_out();
		end
	end

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	function automatic logic [31:0] pat(input int i);
		return {8'(i), ~8'(i), 16'hC35A};
	endfunction
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic bus(input logic ao, wr, input logic [5:0] a, input logic [31:0] d,
			input logic [3:0] be);
		@(posedge clk_sys);
		if (ao) begin
			{ao_wr, ao_rd, ao_addr, ao_wdata, ao_be} <= {wr, !wr, a, d, be};
		end else begin
			{tgt_wr, tgt_rd, tgt_addr, tgt_wdata, tgt_be} <= {wr, !wr, a, d, be};
		end
		@(posedge clk_sys);
		{tgt_wr, tgt_rd, ao_wr, ao_rd} <= 4'h0;
		#1;
	endtask
	task automatic rd(input logic ao, input logic [5:0] a, input logic [31:0] e, input string nm);
		bus(ao, 1'b0, a, 32'h0, 4'hF);
		chk(nm, e, ao ? ao_rdata : tgt_rdata);
	endtask
	task automatic wait_n(ref logic [31:0] q[$], input int n);
		repeat (600) if (q.size() < n) begin
			@(posedge clk_sys);
			#1;
		end
	endtask
	task automatic wait_irq;
		repeat (200) if (pci_irq !== 1'b1) @(posedge clk_sys);
	endtask
	task automatic close_out;
		if (n_mismatch == 0 && samples_checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		{arst_n, tgt_wr, tgt_rd, ao_bm_mode, ao_wr, ao_rd, ao_wdat_valid, ao_rdat_ready} = '0;
		{tgt_addr, ao_addr, tgt_be, ao_be, lat, fault} = '0;
		{tgt_wdata, ao_wdata} = '0;
		for (int i = 0; i < 64; i++) pbm_mem_model_inst.mem[i] = pat(i);
		repeat (5) @(posedge clk_sys);
		chk("cnt_zero", 32'h3, {wr_cnt_zero, rd_cnt_zero});
		arst_n <= 1'b1;
		foreach (offs[i]) rd(0, offs[i], 32'h0, "reset_value");
		bus(0, 1, 6'h2C, 32'h00001003, 4'hF);
		rd(0, 6'h2C, 32'h00001000, "rd_addr_low");
		// mailbox status, interrupts and acknowledge
		bus(0, 1, 6'h38, 32'h00001F16, 4'hF);
		bus(0, 1, 6'h04, 32'h11223344, 4'h5);
		bus(1, 1, 6'h1C, 32'hDD000000, 4'h8);
		bus(1, 1, 6'h10, 32'h00000077, 4'h1);
		bus(0, 1, 6'h34, 32'hFFFFFFFF, 4'hF);
		rd(0, 6'h34, 32'h80010050, "flags");
		rd(1, 6'h04, 32'h00220044, "out_mbx");
		rd(0, 6'h1C, 32'hDD000000, "in_mbx");
		rd(0, 6'h34, 32'h00010000, "flags_clr");
		rd(0, 6'h38, 32'h00831F16, "icsr_mbx");
		chk("irq", 32'h1, pci_irq);
		bus(0, 1, 6'h38, 32'h00021F16, 4'hF);
		rd(0, 6'h38, 32'h00811F16, "icsr_w1c");
		bus(0, 1, 6'h38, 32'h00011F16, 4'hF);
		rd(0, 6'h38, 32'h00001F16, "icsr_ack");
		chk("irq", 32'h0, pci_irq);
		// add-on access to transfer registers
		bus(1, 1, 6'h30, 32'h00000040, 4'hF);
		rd(1, 6'h30, 32'h0, "ao_cnt_locked");
		@(posedge clk_sys) ao_bm_mode <= 1'b1;
		bus(1, 1, 6'h2C, 32'h00000040, 4'hF);
		bus(1, 1, 6'h30, 32'd38, 4'hF);
		rd(1, 6'h30, 32'd38, "ao_cnt");
		// read transfer, stalled until the buffer refuses
		@(posedge clk_sys) lat <= 4'h6;
		bus(0, 1, 6'h38, 32'h00009F16, 4'hF);
		bus(0, 1, 6'h3C, 32'h2, 4'hF);
		wait_n(log_a, 1);
		rd(0, 6'h2C, 32'h00000044, "rd_addr_live");
		rd(0, 6'h30, 32'd34, "rd_cnt_live");
		@(posedge clk_sys) lat <= 4'h1;
		wait_n(log_a, 8);
		repeat (40) @(posedge clk_sys);
		chk("phases_full", 32'd8, 32'(log_a.size()));
		rd(0, 6'h30, 32'd6, "rd_cnt_full");
		@(posedge clk_sys) ao_rdat_ready <= 1'b1;
		wait_n(log_d, 10);
		for (int i = 0; i < 10; i++) begin
			chk("rd_phase_addr", 32'h40 + 32'(4 * i), log_a[i]);
			chk("rd_phase_be", (i == 9) ? 32'h3 : 32'hF, 32'(log_be[i]));
			chk("rd_word", pat(16 + i) & ((i == 9) ? 32'hFFFF : '1), log_d[i] & ((i == 9) ? 32'hFFFF : '1));
		end
		rd(0, 6'h30, 32'h0, "rd_cnt_end");
		rd(0, 6'h2C, 32'h00000068, "rd_addr_end");
		rd(0, 6'h3C, 32'h0, "ctrl_stop");
		rd(0, 6'h38, 32'h00889F16, "icsr_rd_done");
		// write transfer ending in a three-byte word
		log_a.delete();
		log_be.delete();
		bus(0, 1, 6'h38, 32'h0008DF16, 4'hF);
		bus(0, 1, 6'h24, 32'h00000080, 4'hF);
		bus(0, 1, 6'h28, 32'd7, 4'hF);
		@(posedge clk_sys) ao_wdat_valid <= 1'b1;
		bus(0, 1, 6'h3C, 32'h1, 4'hF);
		wait_n(log_a, 2);
		chk("wr_be", 32'hF7, {log_be[0], log_be[1]});
		chk("wr_addr", 32'h84, log_a[1]);
		chk("mem_full", 32'hA0B0C0D0, pbm_mem_model_inst.mem[32]);
		chk("mem_part", (pat(33) & 32'hFF000000) | 32'h00B1C1D1, pbm_mem_model_inst.mem[33]);
		rd(0, 6'h28, 32'h0, "wr_cnt_end");
		rd(0, 6'h24, 32'h00000088, "wr_addr_end");
		rd(0, 6'h38, 32'h0084DF16, "icsr_wr_done");
		chk("wr_zero", 32'h1, 32'(wr_cnt_zero));
		// target abort on write, master abort on read
		@(posedge clk_sys) fault <= 2'h1;
		bus(0, 1, 6'h38, 32'h0004DF16, 4'hF);
		bus(0, 1, 6'h28, 32'd4, 4'hF);
		bus(0, 1, 6'h3C, 32'h1, 4'hF);
		wait_irq();
		rd(0, 6'h38, 32'h0020DF16, "icsr_tabort");
		rd(0, 6'h28, 32'd4, "wr_cnt_abort");
		rd(0, 6'h3C, 32'h0, "ctrl_abort");
		@(posedge clk_sys) fault <= 2'h2;
		bus(0, 1, 6'h38, 32'h0020DF16, 4'hF);
		bus(0, 1, 6'h30, 32'd4, 4'hF);
		bus(0, 1, 6'h3C, 32'h2, 4'hF);
		wait_irq();
		rd(0, 6'h38, 32'h0010DF16, "icsr_mabort");
		rd(0, 6'h30, 32'd4, "rd_cnt_abort");
		close_out();
	end
endmodule
